// ==== common/ssp_pkg.sv ====
//
// Operation
// R1: The port has eight pins, each usable as general-purpose input or output, with one register bit per pin.
// R2: Every bit of the pin data register is cleared to zero on reset.
// R3: A port read returns the stored data bit for each pin whose direction bit is one.
// R4: A port read returns the synchronised pin level for each pin whose direction bit is zero.
// R5: A direction bit of one makes the pin an output and a direction bit of zero makes it an input.
// R6: Direction and data settings only reach a pin while the segment select field gives it to general-purpose use.
// R7: The direction register is write-only and every read of its address returns all ones.
// R8: Every bit of the direction register is cleared to zero on reset, so all pins start as inputs.
// R9: Pins seven to four carry segment outputs n+17 whenever the segment select field is 0110 to 1101; the code floats them instead while standby is set.
// R10: Pins three to zero carry segment outputs m+17 whenever the segment select field is 0101 to 1100; the code floats them instead while standby is set.
// R11: The pins float during reset and in standby and work normally in active and subactive modes.
// R12: A pin in general-purpose output use drives the level held in its data register bit.
//
`default_nettype none

package ssp_pkg;

   // ************************************************
   // widths
   // ************************************************
   localparam int PORT_W = 8;
   localparam int NIB_W  = 4;
   localparam int SEL_W  = 4;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;

   // ************************************************
   // register indices and byte addresses
   // ************************************************
   localparam logic [15:0]       DATA_IDX  = 16'hffda;
   localparam logic [15:0]       DIR_IDX   = 16'hffea;
   localparam logic [15:0]       CTRL_IDX  = 16'hffd0;
   localparam logic [ADDR_W-1:0] DATA_ADDR = {DATA_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] DIR_ADDR  = {DIR_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};

   // ************************************************
   // control register fields
   // ************************************************
   localparam int CTRL_SEL_POS  = 0;
   localparam int CTRL_STBY_POS = 7;

   // ************************************************
   // reset and fixed read values
   // ************************************************
   localparam logic [PORT_W-1:0] DATA_RST    = 8'h00;
   localparam logic [PORT_W-1:0] DIR_RST     = 8'h00;
   localparam logic [PORT_W-1:0] CTRL_RST    = 8'h00;
   localparam logic [PORT_W-1:0] DIR_READ    = 8'hff;
   localparam logic [PORT_W-1:0] PIN_OUT_RST = 8'h00;
   localparam logic [PORT_W-1:0] OE_N_RST    = 8'hff;
   localparam logic [DATA_W-1:0] UNMAP_READ  = 32'h0000_0000;

   // ************************************************
   // segment select ranges
   // ************************************************
   localparam logic [SEL_W-1:0] HI_SEGMENT_LO = 4'h6;
   localparam logic [SEL_W-1:0] HI_SEGMENT_HI = 4'hd;
   localparam logic [SEL_W-1:0] LO_SEGMENT_LO = 4'h5;
   localparam logic [SEL_W-1:0] LO_SEGMENT_HI = 4'hc;
   localparam int               SEGMENT_FIRST = 17;

endpackage : ssp_pkg

`default_nettype wire

// ==== hw/ssp_nibble_mux.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssp_nibble_mux #(
   parameter logic [ssp_pkg::SEL_W-1:0] SEL_LO = 4'h0,
   parameter logic [ssp_pkg::SEL_W-1:0] SEL_HI = 4'h0
) (
   input  wire logic [ssp_pkg::SEL_W-1:0] segment_sel_i,
   input  wire logic                      standby_i,
   input  wire logic [ssp_pkg::NIB_W-1:0] dir_i,
   input  wire logic [ssp_pkg::NIB_W-1:0] data_i,
   input  wire logic [ssp_pkg::NIB_W-1:0] segment_i,
   output logic                           segment_mode_o,
   output logic      [ssp_pkg::NIB_W-1:0] out_nxt_o,
   output logic      [ssp_pkg::NIB_W-1:0] oe_n_nxt_o
);
   import ssp_pkg::*;

   // ************************************************
   // pin function select
   // ************************************************
   assign segment_mode_o = (segment_sel_i >= SEL_LO) && (segment_sel_i <= SEL_HI); // R9 R10
   // direction and data only count in gpio use
   assign out_nxt_o      = segment_mode_o ? segment_i : data_i; // R6 R12
   // standby beats segment use: the whole nibble floats
   assign oe_n_nxt_o     = standby_i      ? {NIB_W{1'b1}} : // R11
                           segment_mode_o ? {NIB_W{1'b0}} :
                                            ~dir_i; // R5

endmodule : ssp_nibble_mux

`default_nettype wire

// ==== hw/ssp_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssp_port (
   input  wire logic                       sys_clk_i,
   input  wire logic                       reset_n_i,
   input  wire logic [ssp_pkg::ADDR_W-1:0] avs_address_i,
   input  wire logic                       avs_read_i,
   input  wire logic                       avs_write_i,
   input  wire logic [ssp_pkg::DATA_W-1:0] avs_writedata_i,
   input  wire logic [ssp_pkg::BE_W-1:0]   avs_byteenable_i,
   output logic      [ssp_pkg::DATA_W-1:0] avs_readdata_o,
   output logic                            avs_waitrequest_o,
   input  wire logic [ssp_pkg::PORT_W-1:0] pin_in_i,
   output logic      [ssp_pkg::PORT_W-1:0] pin_out_o,
   output logic      [ssp_pkg::PORT_W-1:0] pin_oe_n_o,
   input  wire logic [ssp_pkg::PORT_W-1:0] segment_data_i,
   output logic      [ssp_pkg::SEL_W-1:0]  segment_select_field_o,
   output logic                            standby_o
);
   import ssp_pkg::*;

   // ************************************************
   // declarations
   // ************************************************
   logic [PORT_W-1:0] pin_meta_r;
   logic [PORT_W-1:0] pin_sync_r;
   logic [PORT_W-1:0] pin_data_r;
   logic [PORT_W-1:0] pin_dir_r;
   logic [PORT_W-1:0] ctrl_r;
   logic [PORT_W-1:0] pin_out_r;
   logic [PORT_W-1:0] pin_oe_n_r;
   logic [PORT_W-1:0] pin_out_nxt;
   logic [PORT_W-1:0] pin_oe_n_nxt;
   logic [DATA_W-1:0] readdata_r;
   logic [DATA_W-1:0] readdata_nxt;
   logic              rd_done_r;

   wire               sel_data;
   wire               sel_dir;
   wire               sel_ctrl;
   wire               wr_lane0;
   wire               wr_data;
   wire               wr_dir;
   wire               wr_ctrl;
   wire               rd_take;
   wire [SEL_W-1:0]   segment_sel;
   wire               standby;
   wire               hi_segment;
   wire               lo_segment;
   wire [PORT_W-1:0]  port_read;

   // ************************************************
   // address decode
   // ************************************************
   assign sel_data = (avs_address_i == DATA_ADDR);
   assign sel_dir  = (avs_address_i == DIR_ADDR);
   assign sel_ctrl = (avs_address_i == CTRL_ADDR);

   // registers live in byte lane 0 only
   assign wr_lane0 = avs_write_i && avs_byteenable_i[0];
   assign wr_data  = wr_lane0 && sel_data;
   assign wr_dir   = wr_lane0 && sel_dir;
   assign wr_ctrl  = wr_lane0 && sel_ctrl;

   // ************************************************
   // bus handshake
   // ************************************************
   // writes finish at once; reads wait one cycle for registered data
   assign rd_take           = avs_read_i && !rd_done_r;
   assign avs_waitrequest_o = rd_take;
   assign avs_readdata_o    = readdata_r;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_done_r <= 1'b0;
      end else begin
         rd_done_r <= rd_take;
      end
   end

   // ************************************************
   // pin synchroniser
   // ************************************************
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_meta_r <= DATA_RST;
         pin_sync_r <= DATA_RST;
      end else begin
         pin_meta_r <= pin_in_i;
         pin_sync_r <= pin_meta_r;
      end
   end

   // ************************************************
   // software registers
   // ************************************************
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_data_r <= DATA_RST; // R2
      end else if (wr_data) begin
         pin_data_r <= avs_writedata_i[PORT_W-1:0]; // R1
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_dir_r <= DIR_RST; // R8
      end else if (wr_dir) begin
         pin_dir_r <= avs_writedata_i[PORT_W-1:0]; // R5
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= avs_writedata_i[PORT_W-1:0];
      end
   end

   assign segment_sel            = ctrl_r[CTRL_SEL_POS +: SEL_W];
   assign standby                = ctrl_r[CTRL_STBY_POS];
   assign segment_select_field_o = segment_sel;
   assign standby_o              = standby;

   // ************************************************
   // read path
   // ************************************************
   // stored bit for outputs, pin level for inputs
   assign port_read = (pin_dir_r & pin_data_r) | (~pin_dir_r & pin_sync_r); // R3 R4

   assign readdata_nxt = sel_data ? {{(DATA_W-PORT_W){1'b0}}, port_read} :
                         sel_dir  ? {{(DATA_W-PORT_W){1'b0}}, DIR_READ}  : // R7
                         sel_ctrl ? {{(DATA_W-PORT_W){1'b0}}, ctrl_r}    :
                                    UNMAP_READ;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         readdata_r <= UNMAP_READ;
      end else if (rd_take) begin
         readdata_r <= readdata_nxt;
      end
   end

   // ************************************************
   // pin function per nibble
   // ************************************************
   ssp_nibble_mux #(
      .SEL_LO (HI_SEGMENT_LO),
      .SEL_HI (HI_SEGMENT_HI)
   ) u_hi_nibble (
      .segment_sel_i  (segment_sel),
      .standby_i      (standby),
      .dir_i          (pin_dir_r[PORT_W-1:NIB_W]),
      .data_i         (pin_data_r[PORT_W-1:NIB_W]),
      .segment_i      (segment_data_i[PORT_W-1:NIB_W]),
      .segment_mode_o (hi_segment),
      .out_nxt_o      (pin_out_nxt[PORT_W-1:NIB_W]),
      .oe_n_nxt_o     (pin_oe_n_nxt[PORT_W-1:NIB_W])
   );

   ssp_nibble_mux #(
      .SEL_LO (LO_SEGMENT_LO),
      .SEL_HI (LO_SEGMENT_HI)
   ) u_lo_nibble (
      .segment_sel_i  (segment_sel),
      .standby_i      (standby),
      .dir_i          (pin_dir_r[NIB_W-1:0]),
      .data_i         (pin_data_r[NIB_W-1:0]),
      .segment_i      (segment_data_i[NIB_W-1:0]),
      .segment_mode_o (lo_segment),
      .out_nxt_o      (pin_out_nxt[NIB_W-1:0]),
      .oe_n_nxt_o     (pin_oe_n_nxt[NIB_W-1:0])
   );

   // ************************************************
   // pin drivers
   // ************************************************
   // registered so the pads never glitch while the mux settles
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_out_r  <= PIN_OUT_RST;
         pin_oe_n_r <= OE_N_RST; // R11
      end else begin
         pin_out_r  <= pin_out_nxt; // R12
         pin_oe_n_r <= pin_oe_n_nxt;
      end
   end

   assign pin_out_o  = pin_out_r;
   assign pin_oe_n_o = pin_oe_n_r;

   // ************************************************
   // assertions
   // ************************************************
   property p_data_write;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (avs_write_i && avs_byteenable_i[0] && sel_data)
      |=> (pin_data_r == $past(avs_writedata_i[PORT_W-1:0]));
   endproperty
   a_data_write: assert property (p_data_write) // R1
      else $error("data register missed a write");

   property p_data_reset;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !$past(reset_n_i) |-> (pin_data_r == DATA_RST);
   endproperty
   a_data_reset: assert property (p_data_reset) // R2
      else $error("data register not cleared by reset");

   property p_read_output;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (avs_read_i && !avs_waitrequest_o && sel_data)
      |-> ((avs_readdata_o[PORT_W-1:0] & $past(pin_dir_r))
           == ($past(pin_data_r) & $past(pin_dir_r)));
   endproperty
   a_read_output: assert property (p_read_output) // R3
      else $error("output pin read not from data register");

   property p_read_input;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (avs_read_i && !avs_waitrequest_o && sel_data)
      |-> ((avs_readdata_o[PORT_W-1:0] & ~$past(pin_dir_r))
           == ($past(pin_sync_r) & ~$past(pin_dir_r)));
   endproperty
   a_read_input: assert property (p_read_input) // R4
      else $error("input pin read not from pin level");

   property p_gpio_low;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!standby && !lo_segment)
      |=> (pin_oe_n_o[NIB_W-1:0] == ~$past(pin_dir_r[NIB_W-1:0]))
          && (pin_out_o[NIB_W-1:0] == $past(pin_data_r[NIB_W-1:0]));
   endproperty
   a_gpio_low: assert property (p_gpio_low) // R5
      else $error("low nibble gpio direction or level wrong");

   property p_gpio_high;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!standby && !hi_segment)
      |=> (pin_oe_n_o[PORT_W-1:NIB_W] == ~$past(pin_dir_r[PORT_W-1:NIB_W]))
          && (pin_out_o[PORT_W-1:NIB_W] == $past(pin_data_r[PORT_W-1:NIB_W]));
   endproperty
   a_gpio_high: assert property (p_gpio_high) // R12
      else $error("high nibble gpio direction or level wrong");

   property p_segment_ignores_dir;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!standby && hi_segment && lo_segment) [*2]
      |-> (pin_oe_n_o == {PORT_W{1'b0}});
   endproperty
   a_segment_ignores_dir: assert property (p_segment_ignores_dir) // R6
      else $error("direction register reached a segment pin");

   property p_dir_read;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (avs_read_i && !avs_waitrequest_o && sel_dir)
      |-> (avs_readdata_o == {{(DATA_W-PORT_W){1'b0}}, DIR_READ});
   endproperty
   a_dir_read: assert property (p_dir_read) // R7
      else $error("direction read not all ones");

   property p_dir_reset;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      !$past(reset_n_i) |-> (pin_dir_r == DIR_RST) && (pin_oe_n_o == OE_N_RST);
   endproperty
   a_dir_reset: assert property (p_dir_reset) // R8
      else $error("direction not cleared by reset");

   property p_segment_high;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!standby && (segment_sel >= HI_SEGMENT_LO) && (segment_sel <= HI_SEGMENT_HI))
      |=> (pin_oe_n_o[PORT_W-1:NIB_W] == {NIB_W{1'b0}})
          && (pin_out_o[PORT_W-1:NIB_W] == $past(segment_data_i[PORT_W-1:NIB_W]));
   endproperty
   a_segment_high: assert property (p_segment_high) // R9
      else $error("high nibble not carrying segment data");

   property p_segment_low;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!standby && (segment_sel >= LO_SEGMENT_LO) && (segment_sel <= LO_SEGMENT_HI))
      |=> (pin_oe_n_o[NIB_W-1:0] == {NIB_W{1'b0}})
          && (pin_out_o[NIB_W-1:0] == $past(segment_data_i[NIB_W-1:0]));
   endproperty
   a_segment_low: assert property (p_segment_low) // R10
      else $error("low nibble not carrying segment data");

   property p_standby_float;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      standby |=> (pin_oe_n_o == {PORT_W{1'b1}});
   endproperty
   a_standby_float: assert property (p_standby_float) // R11
      else $error("pins driven in standby");

   property p_read_wait;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o;
   endproperty
   a_read_wait: assert property (p_read_wait) // R3
      else $error("read answer later than one wait cycle");

endmodule : ssp_port

`default_nettype wire

// ==== tb/ssp_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ************************************************
// board side of the port pins
// ************************************************
module ssp_board_model (
   input  wire logic                       sys_clk_i,
   input  wire logic [ssp_pkg::PORT_W-1:0] pin_out_i,
   input  wire logic [ssp_pkg::PORT_W-1:0] pin_oe_n_i,
   input  wire logic [ssp_pkg::PORT_W-1:0] ext_en_i,
   input  wire logic [ssp_pkg::PORT_W-1:0] ext_val_i,
   output logic      [ssp_pkg::PORT_W-1:0] pin_level_o
);
   import ssp_pkg::*;
   // undriven lines wander, so a stale level never passes for a real one
   logic [PORT_W-1:0] float_r = 8'h5a;
   always @(posedge sys_clk_i) begin
      float_r <= ~float_r;
   end
   assign pin_level_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_en_i & ext_val_i)
                      | (pin_oe_n_i & ~ext_en_i & float_r);
endmodule : ssp_board_model

`default_nettype wire

// ==== tb/ssp_port_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin errors++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end

module ssp_port_test;
   import ssp_pkg::*;
   typedef struct packed {
      logic [7:0] ctl, dir, dat, ext, lcd, oe_n, out, rd;
   } ssp_row_type;
   // ************************************************
   // ordinary cases: inputs, then pins and read value
   // ************************************************
   localparam ssp_row_type ROWS [9] = '{
      '{8'h00, 8'hf0, 8'ha5, 8'h3c, 8'h00, 8'h0f, 8'ha0, 8'hac},
      '{8'h05, 8'h00, 8'hff, 8'h00, 8'h96, 8'hf0, 8'h06, 8'h06},
      '{8'h06, 8'hff, 8'h00, 8'hff, 8'h5a, 8'h00, 8'h5a, 8'h00},
      '{8'h0c, 8'h00, 8'h00, 8'h00, 8'hc3, 8'h00, 8'hc3, 8'hc3},
      '{8'h0d, 8'h0f, 8'h12, 8'h80, 8'he7, 8'h00, 8'he2, 8'he2},
      '{8'h0e, 8'h55, 8'hff, 8'h00, 8'hff, 8'haa, 8'h55, 8'h55},
      '{8'h04, 8'h00, 8'hff, 8'h5a, 8'hff, 8'hff, 8'h00, 8'h5a},
      '{8'h86, 8'hff, 8'hff, 8'h00, 8'h33, 8'hff, 8'h00, 8'hff},
      '{8'h0f, 8'hff, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h3c}};

   logic              sys_clk;
   logic              reset_n;
   logic              rd_en;
   logic              wr_en;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic [BE_W-1:0]   be;
   logic              wait_q;
   logic [PORT_W-1:0] ext_val;
   logic [PORT_W-1:0] segment_data;
   logic [PORT_W-1:0] pin_level;
   logic [PORT_W-1:0] pin_out;
   logic [PORT_W-1:0] oe_n;
   logic [SEL_W-1:0]  sel;
   logic              stby;
   logic [DATA_W-1:0] got;
   int                errors;
   int                n_compared;

   ssp_port ssp_port_i (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .avs_address_i(addr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_q), .pin_in_i(pin_level), .pin_out_o(pin_out),
      .pin_oe_n_o(oe_n), .segment_data_i(segment_data), .segment_select_field_o(sel), .standby_o(stby));

   ssp_board_model ssp_board_model_i (.sys_clk_i(sys_clk), .pin_out_i(pin_out), .pin_oe_n_i(oe_n),
      .ext_en_i(8'hff), .ext_val_i(ext_val), .pin_level_o(pin_level));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // ************************************************
   // bus cycles
   // ************************************************
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [BE_W-1:0] b);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= {24'h0, d};
      be    <= b;
      wr_en <= 1'b1;
      do @(posedge sys_clk); while (wait_q !== 1'b0);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      do @(posedge sys_clk); while (wait_q !== 1'b0);
      d = rdata;
      rd_en <= 1'b0;
   endtask : rd

   // reset with pins checked while it is held and registers checked after
   task automatic do_reset();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      `CHK("oe_n in reset", 8'hff, oe_n)
      reset_n <= 1'b1;
      @(posedge sys_clk);
      `CHK("oe_n after reset", 8'hff, oe_n)
      rd(DIR_ADDR, got);
      `CHK("dir read", 32'h0000_00ff, got)
      wr(DIR_ADDR, 8'hff, 4'h1);
      repeat (2) @(posedge sys_clk);
      `CHK("oe_n dir ff", 8'h00, oe_n)
      `CHK("out reset", 8'h00, pin_out)
      rd(DATA_ADDR, got);
      `CHK("data reset", 32'h0, got)
      $display("test reset done");
   endtask : do_reset

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (6000) @(posedge sys_clk);
      errors++;
      conclude();
   end

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      reset_n = 1'b0; rd_en = 1'b0; wr_en = 1'b0; addr = '0; wdata = '0;
      be = 4'h1; ext_val = 8'h00; segment_data = 8'h00; errors = 0; n_compared = 0;
      do_reset();
      foreach (ROWS[i]) begin
         ext_val <= ROWS[i].ext;
         segment_data <= ROWS[i].lcd;
         wr(CTRL_ADDR, ROWS[i].ctl, 4'h1);
         wr(DIR_ADDR, ROWS[i].dir, 4'h1);
         wr(DATA_ADDR, ROWS[i].dat, 4'h1);
         repeat (4) @(posedge sys_clk);
         `CHK("select", ROWS[i].ctl[3:0], sel)
         `CHK("standby", ROWS[i].ctl[7], stby)
         `CHK("oe_n", ROWS[i].oe_n, oe_n)
         `CHK("driven out", ROWS[i].out, pin_out & ~oe_n)
         rd(DATA_ADDR, got);
         `CHK("port read", {24'h0, ROWS[i].rd}, got)
         $display("test row %0d done", i);
      end
      // byte lane off, unmapped place, direction still unreadable
      wr(DATA_ADDR, 8'h81, 4'h0);
      wr(18'h00010, 8'h81, 4'h1);
      rd(DATA_ADDR, got);
      `CHK("masked write", 32'h0000_003c, got)
      rd(18'h00010, got);
      `CHK("unmapped read", 32'h0, got)
      rd(DIR_ADDR, got);
      `CHK("dir read set", 32'h0000_00ff, got)
      rd(CTRL_ADDR, got);
      `CHK("ctrl read", 32'h0000_000f, got)
      `CHK("out held", 8'h3c, pin_out)
      $display("test refusals done");
      do_reset();
      conclude();
   end
endmodule : ssp_port_test

`default_nettype wire
